// File: inc/osr_pkg.sv
/*
 * constants, carriers and state types of the output setpoint reference logic.
 * assumes one 200 MHz core clock and a same-clock command engine in front of it.
 */
// Operation
// - scale accepts only one, half, quarter
// - out-of-limit command clamps, sets status bit
// - signed trim -64..+63 steps added
// - margin high/low steps -64..+31 held
// - operation bits five/four add margin steps
// - reference = command*scale + trim + margins
// - reference bounded to DAC code span
// - reset pin low loads boot setpoint
// - ramp starts within 2 us, rate-limited
// - command writes ignored while pin low
// - pin reset sets vendor status flag
// - option bit restores boot setpoint on restart
`default_nettype none

package osr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
    localparam logic [7:0] CMD_UPPER_LIMIT = 8'h24;
    localparam logic [7:0] CMD_TRANSITION_RATE = 8'h27;
    localparam logic [7:0] CMD_LOWER_LIMIT = 8'h28;
    localparam logic [7:0] CMD_SCALE = 8'h29;
    localparam logic [7:0] CMD_LIMIT_STATUS = 8'h7A;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CMD_REF_TRIM = 8'hD4;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'hD5;
    localparam logic [7:0] CMD_MARGIN_LOW = 8'hD6;
    localparam logic [7:0] CMD_OPTIONS = 8'hE5;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int OP_MARGIN_HIGH_BIT = 5;
    localparam int OP_MARGIN_LOW_BIT = 4;
    localparam int LIMIT_HIGH_BIT = 3;
    localparam int LIMIT_LOW_BIT = 2;
    localparam int VENDOR_RESET_BIT = 1;
    localparam int OPT_RESTORE_BIT = 7;

    // scale codes, one is the default
    localparam logic [1:0] SCALE_ONE = 2'h0;
    localparam logic [1:0] SCALE_HALF = 2'h1;
    localparam logic [1:0] SCALE_QUARTER = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and code limits
    localparam logic [15:0] UPPER_LIMIT_RST = 16'h0B00;
    localparam logic [15:0] LOWER_LIMIT_RST = 16'h00B3;
    localparam logic [15:0] TRANSITION_RATE_RST = 16'h0063;
    localparam logic [15:0] OPTIONS_RST = 16'h0000;
    localparam logic [7:0] OPERATION_RST = 8'h00;
    localparam logic [9:0] REF_MIN_CODE = 10'h0B3;
    localparam logic [9:0] REF_MAX_CODE = 10'h34D;
    localparam logic signed [15:0] TRIM_MAX = 16'sh003F;
    localparam logic signed [15:0] MARGIN_MAX = 16'sh001F;
    localparam logic signed [15:0] STEP_MIN = 16'shFFC0;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_RAMP_NS = 2000;
    localparam int RESET_RAMP_CYCLES = RESET_RAMP_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers and state
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] data;
    } osr_cmd_s;

    typedef struct packed {
        logic init;
        logic [9:0] target;
        logic [15:0] rate;
    } osr_slew_ctl_s;

    typedef enum logic {SLEW_IDLE, SLEW_RAMP} osr_slew_e;

    typedef struct packed {
        osr_slew_e state;
        logic busy;
        logic [15:0] cnt;
        logic [9:0] ref_code;
    } osr_slew_state_s;

    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic booted;
        logic primed;
        logic init;
        logic [15:0] boot_cmd;
        logic [15:0] vout_cmd;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] rate;
        logic [15:0] options;
        logic [1:0] scale;
        logic [6:0] trim;
        logic [6:0] mhi;
        logic [6:0] mlo;
        logic [7:0] operation;
        logic [7:0] limit_status;
        logic [7:0] vendor_status;
        logic [15:0] rd_data;
        logic rd_valid;
        logic [9:0] target;
    } osr_state_s;

endpackage : osr_pkg

`default_nettype wire

// File: src/osr_slew.sv
/*
 * slew limiter that walks the reference code toward its target one step at a time.
 * assumes target, rate and init come from flops on the same clock.
 */
`default_nettype none

module osr_slew
    import osr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire osr_slew_ctl_s i_ctl,
    output logic [9:0] o_ref,
    output logic o_busy
);

    osr_slew_state_s s;
    osr_slew_state_s next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // step toward the target every rate+1 cycles
    always_comb begin
        next_s = s;
        case (s.state)
            SLEW_IDLE: begin
                if (s.ref_code != i_ctl.target) begin
                    next_s.state = SLEW_RAMP;
                    next_s.cnt = 16'h0000;
                end
            end
            SLEW_RAMP: begin
                if (s.ref_code == i_ctl.target) begin
                    next_s.state = SLEW_IDLE;
                end else if (s.cnt == 16'h0000) begin
                    next_s.ref_code = (s.ref_code < i_ctl.target) ? s.ref_code + 10'h001 : s.ref_code - 10'h001;
                    next_s.cnt = i_ctl.rate;
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            default: next_s.state = SLEW_IDLE;
        endcase
        // boot load jumps straight to the target
        if (i_ctl.init) begin
            next_s.ref_code = i_ctl.target;
            next_s.state = SLEW_IDLE;
        end
        next_s.busy = (next_s.state == SLEW_RAMP);
    end

    // state register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{state: SLEW_IDLE, busy: 1'b0, cnt: 16'h0000, ref_code: REF_MIN_CODE};
        end else begin
            s <= next_s;
        end
    end

    assign o_ref = s.ref_code;
    assign o_busy = s.busy;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    property p_ramp_enter;
        (s.state == SLEW_IDLE && s.ref_code != i_ctl.target && !i_ctl.init) |=> (s.state == SLEW_RAMP && s.cnt == 16'h0000);
    endproperty
    a_ramp_enter: assert property (p_ramp_enter) else $error("ramp not entered");

    property p_ramp_step;
        (s.state == SLEW_RAMP && s.cnt == 16'h0000 && s.ref_code != i_ctl.target && !i_ctl.init)
            |=> (s.ref_code == $past(s.ref_code) + 10'h001 || s.ref_code == $past(s.ref_code) - 10'h001);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp step missing");

endmodule : osr_slew

`default_nettype wire

// File: src/osr_setpoint.sv
/*
 * output setpoint reference logic: command registers, limit clamp, reference sum,
 * setpoint reset pin and restart restore, feeding the slew limiter.
 * assumes a same-clock command engine, a same-clock boot value and restart pulse,
 * and an asynchronous reset pin that is synchronised here.
 */
`default_nettype none

module osr_setpoint
    import osr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_setpoint_reset_pin_n,
    input wire logic [15:0] i_boot_setpoint,
    input wire logic i_fault_restart,
    input wire osr_cmd_s i_cmd,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic [9:0] o_error_amp_reference,
    output logic o_ramp_busy
);

    osr_state_s st;
    osr_state_s next_st;
    osr_slew_ctl_s slew_ctl;
    logic pin_fall;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // sign-extend a 7-bit step
    function automatic logic signed [18:0] sx19(input logic [6:0] v);
        sx19 = $signed({{12{v[6]}}, v});
    endfunction : sx19

    // saturate a written step to [-64, hi]
    function automatic logic [6:0] sat7(input logic [15:0] d, input logic signed [15:0] hi);
        logic signed [15:0] v;
        v = $signed(d);
        if (v > hi) begin
            sat7 = hi[6:0];
        end else if (v < STEP_MIN) begin
            sat7 = STEP_MIN[6:0];
        end else begin
            sat7 = d[6:0];
        end
    endfunction : sat7

    // reference code from command, scale, trim and margins
    function automatic logic [9:0] calc_ref(
        input logic [15:0] cmd,
        input logic [1:0] sc,
        input logic [6:0] tr,
        input logic [7:0] op,
        input logic [6:0] hi,
        input logic [6:0] lo
    );
        logic [15:0] base;
        logic signed [18:0] sum;
        base = cmd >> sc;
        sum = $signed({3'b000, base}) + sx19(tr);
        if (op[OP_MARGIN_HIGH_BIT]) begin
            sum = sum + sx19(hi);
        end
        if (op[OP_MARGIN_LOW_BIT]) begin
            sum = sum + sx19(lo);
        end
        if (sum < $signed({9'h000, REF_MIN_CODE})) begin
            calc_ref = REF_MIN_CODE;
        end else if (sum > $signed({9'h000, REF_MAX_CODE})) begin
            calc_ref = REF_MAX_CODE;
        end else begin
            calc_ref = sum[9:0];
        end
    endfunction : calc_ref

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    assign pin_fall = st.pin_prev & ~st.pin_sync;

    always_comb begin
        next_st = st;
        next_st.pin_meta = i_setpoint_reset_pin_n;
        next_st.pin_sync = st.pin_meta;
        next_st.pin_prev = st.pin_sync;
        next_st.rd_valid = 1'b0;
        next_st.primed = st.booted;
        next_st.init = st.booted & ~st.primed;

        // host writes
        if (i_cmd.wr) begin
            case (i_cmd.code)
                CMD_OPERATION: next_st.operation = i_cmd.data[7:0];
                CMD_CLEAR_FAULTS: begin
                    next_st.limit_status = 8'h00;
                    next_st.vendor_status = 8'h00;
                end
                CMD_VOUT_COMMAND: begin
                    if (st.pin_sync) begin
                        if (i_cmd.data > st.upper) begin
                            next_st.vout_cmd = st.upper;
                            next_st.limit_status[LIMIT_HIGH_BIT] = 1'b1;
                        end else if (i_cmd.data < st.lower) begin
                            next_st.vout_cmd = st.lower;
                            next_st.limit_status[LIMIT_LOW_BIT] = 1'b1;
                        end else begin
                            next_st.vout_cmd = i_cmd.data;
                        end
                    end
                end
                CMD_UPPER_LIMIT: next_st.upper = i_cmd.data;
                CMD_TRANSITION_RATE: next_st.rate = i_cmd.data;
                CMD_LOWER_LIMIT: next_st.lower = i_cmd.data;
                CMD_SCALE: begin
                    if (i_cmd.data <= {14'h0000, SCALE_QUARTER}) begin
                        next_st.scale = i_cmd.data[1:0];
                    end
                end
                CMD_REF_TRIM: next_st.trim = sat7(i_cmd.data, TRIM_MAX);
                CMD_MARGIN_HIGH: next_st.mhi = sat7(i_cmd.data, MARGIN_MAX);
                CMD_MARGIN_LOW: next_st.mlo = sat7(i_cmd.data, MARGIN_MAX);
                CMD_OPTIONS: next_st.options = i_cmd.data;
                default: ;
            endcase
        end

        // pin low holds the boot setpoint, fall sets the flag after any clear
        if (!st.pin_sync && st.booted) begin
            next_st.vout_cmd = st.boot_cmd;
        end
        if (pin_fall) begin
            next_st.vendor_status[VENDOR_RESET_BIT] = 1'b1;
        end

        // restart after fault restores the boot setpoint when enabled
        if (i_fault_restart && st.options[OPT_RESTORE_BIT]) begin
            next_st.vout_cmd = st.boot_cmd;
        end

        // first cycle after reset captures the boot setpoint
        if (!st.booted) begin
            next_st.booted = 1'b1;
            next_st.boot_cmd = i_boot_setpoint;
            next_st.vout_cmd = i_boot_setpoint;
        end

        next_st.target = calc_ref(st.vout_cmd, st.scale, st.trim, st.operation, st.mhi, st.mlo);

        // host reads, unmapped codes read zero
        if (i_cmd.rd) begin
            next_st.rd_valid = 1'b1;
            case (i_cmd.code)
                CMD_OPERATION: next_st.rd_data = {8'h00, st.operation};
                CMD_VOUT_COMMAND: next_st.rd_data = st.vout_cmd;
                CMD_UPPER_LIMIT: next_st.rd_data = st.upper;
                CMD_TRANSITION_RATE: next_st.rd_data = st.rate;
                CMD_LOWER_LIMIT: next_st.rd_data = st.lower;
                CMD_SCALE: next_st.rd_data = {14'h0000, st.scale};
                CMD_LIMIT_STATUS: next_st.rd_data = {8'h00, st.limit_status};
                CMD_VENDOR_STATUS: next_st.rd_data = {8'h00, st.vendor_status};
                CMD_REF_TRIM: next_st.rd_data = {{9{st.trim[6]}}, st.trim};
                CMD_MARGIN_HIGH: next_st.rd_data = {{9{st.mhi[6]}}, st.mhi};
                CMD_MARGIN_LOW: next_st.rd_data = {{9{st.mlo[6]}}, st.mlo};
                CMD_OPTIONS: next_st.rd_data = st.options;
                default: next_st.rd_data = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
            st.pin_meta <= 1'b1;
            st.pin_sync <= 1'b1;
            st.pin_prev <= 1'b1;
            st.upper <= UPPER_LIMIT_RST;
            st.lower <= LOWER_LIMIT_RST;
            st.rate <= TRANSITION_RATE_RST;
            st.options <= OPTIONS_RST;
            st.operation <= OPERATION_RST;
            st.scale <= SCALE_ONE;
            st.target <= REF_MIN_CODE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slew limiter and outputs
    assign slew_ctl = '{init: st.init, target: st.target, rate: st.rate};

    osr_slew u_slew (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_ctl(slew_ctl),
        .o_ref(o_error_amp_reference),
        .o_busy(o_ramp_busy)
    );

    assign o_rd_data = st.rd_data;
    assign o_rd_valid = st.rd_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    localparam int RampLim = RESET_RAMP_CYCLES;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    property p_scale_legal;
        st.scale != 2'h3;
    endproperty
    a_scale_legal: assert property (p_scale_legal) else $error("illegal scale held");

    property p_clamp_high;
        (i_cmd.wr && i_cmd.code == CMD_VOUT_COMMAND && st.pin_sync && st.booted && !i_fault_restart
            && i_cmd.data > st.upper) |=> (st.vout_cmd == $past(st.upper) && st.limit_status[LIMIT_HIGH_BIT]);
    endproperty
    a_clamp_high: assert property (p_clamp_high) else $error("upper clamp failed");

    property p_clamp_low;
        (i_cmd.wr && i_cmd.code == CMD_VOUT_COMMAND && st.pin_sync && st.booted && !i_fault_restart
            && i_cmd.data < st.lower) |=> (st.vout_cmd == $past(st.lower) && st.limit_status[LIMIT_LOW_BIT]);
    endproperty
    a_clamp_low: assert property (p_clamp_low) else $error("lower clamp failed");

    property p_margin_range;
        $signed(st.mhi) <= 7'sd31 && $signed(st.mlo) <= 7'sd31;
    endproperty
    a_margin_range: assert property (p_margin_range) else $error("margin step above range");

    property p_margin_high;
        // trim of -5 plus a high step of +20 gives +15 on the code
        (st.operation[5:4] == 2'b10 && st.scale == SCALE_ONE && st.trim == 7'h7B && st.mhi == 7'h14
            && st.vout_cmd >= 16'h00C8 && st.vout_cmd <= 16'h0320) |=> st.target == $past(st.vout_cmd[9:0]) + 10'h00F;
    endproperty
    a_margin_high: assert property (p_margin_high) else $error("high margin not added");

    property p_scale_half;
        (st.scale == SCALE_HALF && st.trim == 7'h7B && st.operation[5:4] == 2'b00
            && st.vout_cmd >= 16'h0170 && st.vout_cmd <= 16'h069A) |=> st.target == $past(st.vout_cmd[10:1]) - 10'h005;
    endproperty
    a_scale_half: assert property (p_scale_half) else $error("half scale reference wrong");

    property p_trim_negative;
        // -64 must pull the floor code below the span and clamp, +64 would not
        (st.scale == SCALE_ONE && st.operation[5:4] == 2'b00 && st.trim == 7'h40 && st.vout_cmd == 16'h00B3)
            |=> st.target == 10'h0B3;
    endproperty
    a_trim_negative: assert property (p_trim_negative) else $error("trim not sign-extended");

    property p_ref_range;
        st.target >= REF_MIN_CODE && st.target <= REF_MAX_CODE;
    endproperty
    a_ref_range: assert property (p_ref_range) else $error("reference outside DAC span");

    property p_pin_load;
        ($fell(st.pin_sync) && st.booted) |=> st.vout_cmd == $past(st.boot_cmd);
    endproperty
    a_pin_load: assert property (p_pin_load) else $error("boot setpoint not loaded");

    property p_pin_ramp;
        ($fell(st.pin_sync) && st.booted) |-> ##[3:RampLim] (o_ramp_busy || o_error_amp_reference == st.target);
    endproperty
    a_pin_ramp: assert property (p_pin_ramp) else $error("reset ramp late");

    property p_ignore_held;
        (i_cmd.wr && i_cmd.code == CMD_VOUT_COMMAND && !st.pin_sync && st.booted) |=> st.vout_cmd == $past(st.boot_cmd);
    endproperty
    a_ignore_held: assert property (p_ignore_held) else $error("write taken while pin low");

    property p_pin_flag;
        $fell(st.pin_sync) |=> st.vendor_status[VENDOR_RESET_BIT];
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("reset flag not set");

    property p_restart;
        (i_fault_restart && st.options[OPT_RESTORE_BIT] && st.booted) |=> st.vout_cmd == $past(st.boot_cmd);
    endproperty
    a_restart: assert property (p_restart) else $error("restart restore failed");

    c_clamp_high: cover property (i_cmd.wr && i_cmd.code == CMD_VOUT_COMMAND && i_cmd.data > st.upper);
    c_pin_reset: cover property ($fell(st.pin_sync) ##[1:20] o_ramp_busy);
    c_margin_low: cover property (st.operation[OP_MARGIN_LOW_BIT] && o_ramp_busy);

endmodule : osr_setpoint

`default_nettype wire

// File: tb/osr_host.sv
/*
 * host model on the command port: one-cycle write and read strobes.
 * assumes the bench calls its tasks and shares the 200 MHz core clock.
 */
`default_nettype none

module osr_host
    import osr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data,
    output var osr_cmd_s o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_cmd = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // one write: strobe set after an edge, held over one sampling edge
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge i_clock);
        #1;
        o_cmd = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
        @(posedge i_clock);
        #1;
        o_cmd = '0;
    endtask : wr

    // one read: answer taken when the valid pulse shows, bounded wait
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        int n;
        @(posedge i_clock);
        #1;
        o_cmd = '{wr: 1'b0, rd: 1'b1, code: code, data: 16'h0000};
        @(posedge i_clock);
        #1;
        o_cmd = '0;
        ok = 1'b0;
        data = 16'h0000;
        for (n = 0; n < 4 && !ok; n++) begin
            if (i_rd_valid === 1'b1) begin
                ok = 1'b1;
                data = i_rd_data;
            end else begin
                @(posedge i_clock);
                #1;
            end
        end
    endtask : rd
endmodule : osr_host

`default_nettype wire

// File: tb/osr_setpoint_test.sv
/*
 * self-checking bench of the setpoint reference logic.
 * assumes the host model drives commands; boot setpoint is a constant.
 */
`default_nettype none

module osr_setpoint_test;
    import osr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] BOOT = 16'h0190;
    localparam logic [7:0] CODES [8] = '{CMD_UPPER_LIMIT, CMD_LOWER_LIMIT, CMD_SCALE, CMD_VENDOR_STATUS,
        CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_OPTIONS, 8'h55};
    localparam logic [15:0] RSTS [8] = '{UPPER_LIMIT_RST, LOWER_LIMIT_RST, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, OPTIONS_RST, 16'h0000};

    logic i_clock;
    logic i_rst_n;
    logic pin_n;
    logic restart;
    osr_cmd_s cmd;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [9:0] ref_code;
    logic busy;
    int mismatches = 0;
    int checked = 0;

    osr_setpoint u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_setpoint_reset_pin_n(pin_n),
        .i_boot_setpoint(BOOT), .i_fault_restart(restart), .i_cmd(cmd), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_error_amp_reference(ref_code), .o_ramp_busy(busy));
    osr_host u_host (.i_clock(i_clock), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_cmd(cmd));

    // 200 MHz core clock
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compares and bus helpers
    task automatic cmp_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_reg

    task automatic cmp_ref(input string name, input logic [9:0] exp, input logic [9:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_ref

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic [15:0] mask);
        logic [15:0] d;
        logic ok;
        u_host.rd(code, d, ok);
        cmp_reg("read valid", 16'h0001, {15'h0000, ok});
        cmp_reg($sformatf("register %h", code), exp, d & mask);
    endtask : rd_chk

    // let the ramp start, then wait for it to finish, bounded
    task automatic settle(input logic [9:0] exp);
        int n;
        repeat (4) @(posedge i_clock);
        #1;
        for (n = 0; n < 2000 && busy !== 1'b0; n++) begin
            @(posedge i_clock);
            #1;
        end
        cmp_ref("reference", exp, ref_code);
    endtask : settle

    task automatic set_chk(input logic [7:0] code, input logic [15:0] data, input logic [9:0] exp);
        u_host.wr(code, data);
        settle(exp);
    endtask : set_chk

    task automatic pulse_restart();
        @(posedge i_clock);
        #1;
        restart = 1'b1;
        @(posedge i_clock);
        #1;
        restart = 1'b0;
    endtask : pulse_restart

    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // watchdog, far beyond the expected run
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        int n;
        i_rst_n = 1'b0;
        pin_n = 1'b1;
        restart = 1'b0;
        repeat (10) @(posedge i_clock);
        #1;
        cmp_ref("reset reference", REF_MIN_CODE, ref_code);
        i_rst_n = 1'b1;
        settle(10'h190);
        foreach (CODES[i]) rd_chk(CODES[i], RSTS[i], 16'hFFFF);
        u_host.wr(CMD_VENDOR_STATUS, 16'hFFFF);
        rd_chk(CMD_VENDOR_STATUS, 16'h0000, 16'hFFFF);
        u_host.wr(CMD_TRANSITION_RATE, 16'h0000);
        $display("test reset values done");
        // clamp to limits
        u_host.wr(CMD_UPPER_LIMIT, 16'h01F4);
        set_chk(CMD_VOUT_COMMAND, 16'h0258, 10'h1F4);
        rd_chk(CMD_VOUT_COMMAND, 16'h01F4, 16'hFFFF);
        rd_chk(CMD_LIMIT_STATUS, 16'h0008, 16'h0008);
        // raised floor so the low code stays inside the scale-one span
        u_host.wr(CMD_LOWER_LIMIT, 16'h00C8);
        set_chk(CMD_VOUT_COMMAND, 16'h00B4, 10'h0C8);
        rd_chk(CMD_VOUT_COMMAND, 16'h00C8, 16'hFFFF);
        rd_chk(CMD_LIMIT_STATUS, 16'h0004, 16'h0004);
        u_host.wr(CMD_UPPER_LIMIT, UPPER_LIMIT_RST);
        u_host.wr(CMD_LOWER_LIMIT, LOWER_LIMIT_RST);
        $display("test limit clamp done");
        // reference sum with trim, margins and scale
        u_host.wr(CMD_REF_TRIM, 16'hFFFB);
        rd_chk(CMD_REF_TRIM, 16'hFFFB, 16'hFFFF);
        u_host.wr(CMD_MARGIN_HIGH, 16'h0014);
        u_host.wr(CMD_MARGIN_LOW, 16'hFFE2);
        set_chk(CMD_VOUT_COMMAND, 16'h0190, 10'h18B);
        set_chk(CMD_OPERATION, 16'h0020, 10'h19F);
        set_chk(CMD_OPERATION, 16'h0010, 10'h16D);
        set_chk(CMD_OPERATION, 16'h0000, 10'h18B);
        set_chk(CMD_SCALE, {14'h0000, SCALE_HALF}, 10'h0C3);
        set_chk(CMD_VOUT_COMMAND, 16'h0320, 10'h18B);
        set_chk(CMD_SCALE, {14'h0000, SCALE_QUARTER}, 10'h0C3);
        set_chk(CMD_VOUT_COMMAND, 16'h0640, 10'h18B);
        u_host.wr(CMD_SCALE, 16'h0003);
        rd_chk(CMD_SCALE, {14'h0000, SCALE_QUARTER}, 16'hFFFF);
        u_host.wr(CMD_SCALE, {14'h0000, SCALE_ONE});
        u_host.wr(CMD_REF_TRIM, 16'h0064);
        rd_chk(CMD_REF_TRIM, TRIM_MAX, 16'hFFFF);
        u_host.wr(CMD_MARGIN_HIGH, 16'h0040);
        rd_chk(CMD_MARGIN_HIGH, MARGIN_MAX, 16'hFFFF);
        u_host.wr(CMD_MARGIN_LOW, 16'hFF00);
        rd_chk(CMD_MARGIN_LOW, STEP_MIN, 16'hFFFF);
        set_chk(CMD_VOUT_COMMAND, 16'h034D, 10'h34D);
        set_chk(CMD_OPERATION, 16'h0010, 10'h34C);
        u_host.wr(CMD_OPERATION, 16'h0000);
        u_host.wr(CMD_REF_TRIM, 16'hFFC0);
        set_chk(CMD_VOUT_COMMAND, 16'h00B3, 10'h0B3);
        u_host.wr(CMD_REF_TRIM, 16'h0000);
        $display("test reference sum done");
        // setpoint reset pin
        set_chk(CMD_VOUT_COMMAND, 16'h012C, 10'h12C);
        pin_n = 1'b0;
        for (n = 0; n < 400 && ref_code === 10'h12C; n++) begin
            @(posedge i_clock);
            #1;
        end
        cmp_reg("ramp start", 16'h0001, {15'h0000, n < 400});
        u_host.wr(CMD_VOUT_COMMAND, 16'h01F4);
        settle(10'h190);
        rd_chk(CMD_VOUT_COMMAND, BOOT, 16'hFFFF);
        rd_chk(CMD_VENDOR_STATUS, 16'h0002, 16'h0002);
        pin_n = 1'b1;
        u_host.wr(CMD_CLEAR_FAULTS, 16'h0000);
        rd_chk(CMD_VENDOR_STATUS, 16'h0000, 16'h0002);
        $display("test reset pin done");
        // restore on restart, option off then on
        set_chk(CMD_VOUT_COMMAND, 16'h012C, 10'h12C);
        pulse_restart();
        rd_chk(CMD_VOUT_COMMAND, 16'h012C, 16'hFFFF);
        u_host.wr(CMD_OPTIONS, 16'h0080);
        pulse_restart();
        rd_chk(CMD_VOUT_COMMAND, BOOT, 16'hFFFF);
        settle(10'h190);
        $display("test restart restore done");
        end_sim();
    end
endmodule : osr_setpoint_test

`default_nettype wire
